// file: design/atd_pkg.sv
package atd_pkg;
  localparam int          ADDR_W        = 32;
  localparam int          REG_ADDR_W    = 24;
  localparam int          NUM_REGIONS   = 16;
  localparam logic [23:0] REGION_BASE   = 24'h100000;
  localparam logic [23:0] REGION_LAST   = 24'h100078;
  localparam int          REGION_STRIDE = 8;
  localparam logic [63:0] REGION_RESET  = 64'h0;
  localparam int          UPPER_MSB     = 63;
  localparam int          UPPER_LSB     = 44;
  localparam int          PITCH_MSB     = 41;
  localparam int          PITCH_LSB     = 32;
  localparam int          LOWER_MSB     = 31;
  localparam int          LOWER_LSB     = 12;
  localparam int          WALK_BIT      = 1;
  localparam int          VALID_BIT     = 0;
  localparam int          PAGE_SHIFT    = 12;
  localparam int          UNIT_SHIFT    = 7;
  localparam int          X_WIDTH_SHIFT = 9;
  localparam int          Y_WIDTH_SHIFT = 7;
  localparam int          X_ROWS_SHIFT  = 3;
  localparam int          Y_ROWS_SHIFT  = 5;
  localparam int          OWORD_SHIFT   = 4;
  localparam int          X_PITCH_DIV   = 2;
endpackage : atd_pkg

// file: design/atd_region_match.sv
`timescale 1ns/10ps
`default_nettype none
module atd_region_match
  import atd_pkg::*;
(
  input  wire logic [NUM_REGIONS*64-1:0] regions,
  input  wire logic [ADDR_W-1:0]         offset,
  output logic                           hit,
  output logic [3:0]                     index
);
  logic [NUM_REGIONS-1:0] match;

  // Lowest index wins; overlapping valid regions are undefined anyway
  always_comb
  begin
    hit   = 1'b0;
    index = 4'h0;
    for (int i = NUM_REGIONS - 1; i >= 0; i--)
    begin
      match[i] = regions[i*64+VALID_BIT] &&
                 offset[ADDR_W-1:PAGE_SHIFT] >= regions[i*64+LOWER_LSB +: 20] &&
                 offset[ADDR_W-1:PAGE_SHIFT] <= regions[i*64+UPPER_LSB +: 20];
      if (match[i])
      begin
        hit   = 1'b1;
        index = 4'(i);
      end
    end
  end
endmodule : atd_region_match
`default_nettype wire

// file: design/atd_detiler.sv
`timescale 1ns/10ps
`default_nettype none
module atd_detiler
  import atd_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Register port
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [63:0]           reg_wdata,
  output logic [63:0]                reg_rdata,
  output logic                       reg_rvalid,
  // Access request
  input  wire logic                  req_valid,
  input  wire logic                  req_is_host,
  input  wire logic                  req_private_gfx_space,
  input  wire logic [ADDR_W-1:0]     req_graphics_aperture_offset,
  // Explicit tiling parameters for internal clients
  input  wire logic                  req_explicit_tiled,
  input  wire logic                  req_explicit_walk_y,
  input  wire logic [9:0]            req_explicit_pitch,
  input  wire logic [ADDR_W-1:0]     req_explicit_base,
  // Translated result, one cycle later
  output logic                       out_valid,
  output logic                       out_tiled,
  output logic [ADDR_W-1:0]          out_addr
);
  ////////////////////////////////////////////////////////////////////////////
  logic [63:0]           region [NUM_REGIONS];
  logic [NUM_REGIONS*64-1:0] region_flat;
  wire                   reg_in_range;
  wire [3:0]             reg_index;
  logic                  match_hit;
  logic [3:0]            match_index;

  assign reg_in_range = reg_addr >= REGION_BASE && reg_addr <= REGION_LAST + 24'h7 &&
                        reg_addr[2:0] == 3'h0;
  assign reg_index    = reg_addr[6:3];

  // Reset value only on full reset; a graphics reset does not touch these
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NUM_REGIONS; i++)
    begin
      if (srst)
        region[i] <= REGION_RESET;
      else if (reg_wr && reg_in_range && reg_index == 4'(i))
        region[i] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      reg_rvalid <= 1'b0;
      reg_rdata  <= 64'h0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= (reg_rd && reg_in_range) ? region[reg_index] : 64'h0;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_REGIONS; i++)
      region_flat[i*64 +: 64] = region[i];
  end

  atd_region_match atd_region_match_inst
  (
    .regions (region_flat),
    .offset  (req_graphics_aperture_offset),
    .hit     (match_hit),
    .index   (match_index)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tiling arithmetic for region and explicit paths
  function automatic logic [ADDR_W-1:0] tile_offset
  (
    input logic [ADDR_W-1:0] lin,
    input logic [10:0]       pitch_tiles,
    input logic              walk_y
  );
    logic [ADDR_W-1:0] tw_shift;
    logic [ADDR_W-1:0] in_tile_w;
    logic [ADDR_W-1:0] xoff;
    logic [ADDR_W-1:0] y;
    logic [ADDR_W-1:0] tile_x;
    logic [ADDR_W-1:0] tile_y;
    logic [ADDR_W-1:0] yin;
    logic [ADDR_W-1:0] xin;
    logic [ADDR_W-1:0] pitch;
    logic [ADDR_W-1:0] res;
    tw_shift  = walk_y ? ADDR_W'(Y_WIDTH_SHIFT) : ADDR_W'(X_WIDTH_SHIFT);
    pitch     = (pitch_tiles == 11'h0) ? ADDR_W'(1) : ADDR_W'(pitch_tiles);
    in_tile_w = lin >> tw_shift;
    xoff      = lin & ((ADDR_W'(1) << tw_shift) - ADDR_W'(1));
    y         = in_tile_w / pitch;
    tile_x    = in_tile_w % pitch;
    yin       = walk_y ? (y & ADDR_W'(31)) : (y & ADDR_W'(7));
    tile_y    = walk_y ? (y >> Y_ROWS_SHIFT) : (y >> X_ROWS_SHIFT);
    xin       = xoff;
    res       = ((tile_y * pitch + tile_x) << PAGE_SHIFT);
    if (walk_y)
      res = res + ((xin >> OWORD_SHIFT) << (Y_ROWS_SHIFT + OWORD_SHIFT)) +
            (yin << OWORD_SHIFT) + (xin & ADDR_W'(15));
    else
      res = res + (yin << X_WIDTH_SHIFT) + xin;
    return res;
  endfunction : tile_offset

  ////////////////////////////////////////////////////////////////////////////
  wire                region_path;
  wire [63:0]         sel_region;
  wire [10:0]         pitch_units;
  wire [10:0]         sel_pitch;
  wire [ADDR_W-1:0]   region_base;
  wire [ADDR_W-1:0]   next_addr;
  wire                next_tiled;

  // Only host aperture accesses outside private space consult regions
  assign region_path = req_is_host && !req_private_gfx_space && match_hit;
  assign sel_region  = region[match_index];
  // Pitch field counts 128B units less one; X tiles need it divided into 512B widths.
  // Eleven bits, so the widest pitch of 1024 Y widths does not wrap to zero.
  assign pitch_units = {1'b0, sel_region[PITCH_MSB:PITCH_LSB]} + 11'h1;
  assign sel_pitch   = sel_region[WALK_BIT] ? pitch_units : (pitch_units >> X_PITCH_DIV);
  assign region_base = {sel_region[LOWER_MSB:LOWER_LSB], 12'h0};
  assign next_tiled  = region_path || (!req_is_host && req_explicit_tiled);
  assign next_addr   = region_path ?
      region_base + tile_offset(req_graphics_aperture_offset - region_base,
                                sel_pitch, sel_region[WALK_BIT]) :
      (!req_is_host && req_explicit_tiled) ?
      req_explicit_base + tile_offset(req_graphics_aperture_offset, {1'b0, req_explicit_pitch},
                                      req_explicit_walk_y) :
      req_graphics_aperture_offset;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      out_valid <= 1'b0;
      out_tiled <= 1'b0;
      out_addr  <= '0;
    end
    else
    begin
      out_valid <= req_valid;
      out_tiled <= req_valid && next_tiled;
      out_addr  <= next_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_miss_passthru;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && req_is_host && !match_hit) |=> (out_addr == $past(req_graphics_aperture_offset));
  endproperty
  a_miss_passthru: assert property (p_miss_passthru) else $error("miss altered address");

  property p_private_linear;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && req_is_host && req_private_gfx_space) |=> !out_tiled;
  endproperty
  a_private_linear: assert property (p_private_linear) else $error("private space tiled");

  property p_internal_ignores;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && !req_is_host && !req_explicit_tiled) |=> !out_tiled;
  endproperty
  a_internal_ignores: assert property (p_internal_ignores) else $error("region used internally");

  property p_host_hit_tiled;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && req_is_host && !req_private_gfx_space && match_hit) |=> out_tiled;
  endproperty
  a_host_hit_tiled: assert property (p_host_hit_tiled) else $error("hit not tiled");

  property p_valid_follows;
    @(posedge ref_clk) disable iff (srst)
    req_valid |=> out_valid;
  endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("result lost");

  property p_hit_needs_valid;
    @(posedge ref_clk) disable iff (srst)
    match_hit |-> sel_region[VALID_BIT];
  endproperty
  a_hit_needs_valid: assert property (p_hit_needs_valid) else $error("invalid region hit");

  // A write, one idle cycle, then a read of the same word
  sequence s_reg_write;
    reg_wr && reg_in_range;
  endsequence

  sequence s_same_read;
    reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2);
  endsequence

  property p_reg_readback;
    @(posedge ref_clk) disable iff (srst)
    s_reg_write ##1 !reg_wr ##1 s_same_read |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_reg_readback: assert property (p_reg_readback) else $error("readback mismatch");

  property p_linear_x_pitch1;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && region_path && !sel_region[WALK_BIT] && sel_pitch == 11'h1)
      |=> out_addr == $past(req_graphics_aperture_offset);
  endproperty
  a_linear_x_pitch1: assert property (p_linear_x_pitch1) else $error("x pitch1 not linear");

  ////////////////////////////////////////////////////////////////////////////
  // Register side
  property p_rvalid_rise;
    @(posedge ref_clk) disable iff (srst)
    reg_rd |=> reg_rvalid;
  endproperty
  a_rvalid_rise: assert property (p_rvalid_rise) else $error("read not answered");

  property p_rvalid_pulse;
    @(posedge ref_clk) disable iff (srst)
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("stray read answer");

  property p_unmapped_zero;
    @(posedge ref_clk) disable iff (srst)
    (reg_rd && !reg_in_range) |=> reg_rdata == 64'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

  property p_stray_wr;
    @(posedge ref_clk) disable iff (srst)
    (reg_wr && !reg_in_range) |=> $stable(region_flat);
  endproperty
  a_stray_wr: assert property (p_stray_wr) else $error("unmapped write landed");

  property p_wr_lands;
    @(posedge ref_clk) disable iff (srst)
    (reg_wr && reg_in_range) |=> region_flat[{$past(reg_index), 6'h0} +: 64] == $past(reg_wdata);
  endproperty
  a_wr_lands: assert property (p_wr_lands) else $error("write lost");

  // Not disabled by reset on purpose: it watches what reset itself leaves behind
  property p_reset_clears;
    @(posedge ref_clk)
    srst |=> region_flat == '0 && !out_valid && !out_tiled && !reg_rvalid;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

  ////////////////////////////////////////////////////////////////////////////
  // Access side
  property p_idle_quiet;
    @(posedge ref_clk) disable iff (srst)
    !req_valid |=> !out_valid && !out_tiled;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("result without request");

  property p_out_tiled_valid;
    @(posedge ref_clk) disable iff (srst)
    out_tiled |-> out_valid;
  endproperty
  a_out_tiled_valid: assert property (p_out_tiled_valid) else $error("tiled alone");

  property p_explicit_tiled;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && !req_is_host && req_explicit_tiled) |=> out_tiled;
  endproperty
  a_explicit_tiled: assert property (p_explicit_tiled) else $error("explicit not tiled");

  property p_internal_addr;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && !req_is_host && !req_explicit_tiled)
      |=> out_addr == $past(req_graphics_aperture_offset);
  endproperty
  a_internal_addr: assert property (p_internal_addr) else $error("internal addr moved");

  property p_private_addr;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && req_is_host && req_private_gfx_space)
      |=> out_addr == $past(req_graphics_aperture_offset);
  endproperty
  a_private_addr: assert property (p_private_addr) else $error("private addr moved");

  // Region bases are page aligned, so the bytes inside one tile row never move
  property p_x_bytes_kept;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && region_path && !sel_region[WALK_BIT])
      |=> out_addr[X_WIDTH_SHIFT-1:0] == $past(req_graphics_aperture_offset[X_WIDTH_SHIFT-1:0]);
  endproperty
  a_x_bytes_kept: assert property (p_x_bytes_kept) else $error("x row bytes moved");

  property p_y_units_kept;
    @(posedge ref_clk) disable iff (srst)
    (req_valid && region_path && sel_region[WALK_BIT])
      |=> out_addr[OWORD_SHIFT-1:0] == $past(req_graphics_aperture_offset[OWORD_SHIFT-1:0]);
  endproperty
  a_y_units_kept: assert property (p_y_units_kept) else $error("y unit bytes moved");

  property p_hit_in_bounds;
    @(posedge ref_clk) disable iff (srst)
    match_hit |->
      (req_graphics_aperture_offset[ADDR_W-1:PAGE_SHIFT] >= sel_region[LOWER_MSB:LOWER_LSB]) &&
      (req_graphics_aperture_offset[ADDR_W-1:PAGE_SHIFT] <= sel_region[UPPER_MSB:UPPER_LSB]);
  endproperty
  a_hit_in_bounds: assert property (p_hit_in_bounds) else $error("hit outside bounds");
endmodule : atd_detiler
`default_nettype wire

// file: verif/atd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module atd_host_model
  import atd_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic [63:0]           reg_rdata,
  input  wire logic                  reg_rvalid,
  input  wire logic                  out_valid,
  input  wire logic                  out_tiled,
  input  wire logic [ADDR_W-1:0]     out_addr,
  output var logic                   reg_wr,
  output var logic                   reg_rd,
  output var logic [REG_ADDR_W-1:0]  reg_addr,
  output var logic [63:0]            reg_wdata,
  output var logic                   req_valid,
  output var logic                   req_is_host,
  output var logic                   req_private_gfx_space,
  output var logic [ADDR_W-1:0]      req_graphics_aperture_offset,
  output var logic                   req_explicit_tiled,
  output var logic                   req_explicit_walk_y,
  output var logic [9:0]             req_explicit_pitch,
  output var logic [ADDR_W-1:0]      req_explicit_base
);
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, req_valid, req_is_host} = '0;
    {req_private_gfx_space, req_graphics_aperture_offset} = '0;
    {req_explicit_tiled, req_explicit_walk_y, req_explicit_pitch, req_explicit_base} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task wr(input logic [23:0] a, input logic [63:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // Released data bus must not keep looking valid
    reg_wdata = ~d;
  endtask : wr
  task rd(input logic [23:0] a, output logic [63:0] d, output bit ok);
    int n;
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    ok = 0;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (reg_rvalid === 1'b1)
      begin
        ok = 1;
        d = reg_rdata;
      end
      else
        @(negedge ref_clk);
    end
  endtask : rd
  task acc(input bit h, p, et, ewy, input logic [9:0] ep, input logic [31:0] eb, off,
           output logic [31:0] a, output logic t, v);
    @(negedge ref_clk);
    {req_is_host, req_private_gfx_space, req_explicit_tiled, req_explicit_walk_y} = {h, p, et, ewy};
    {req_explicit_pitch, req_explicit_base, req_graphics_aperture_offset} = {ep, eb, off};
    req_valid = 1'b1;
    @(negedge ref_clk);
    {v, t, a} = {out_valid, out_tiled, out_addr};
    req_valid = 1'b0;
    req_graphics_aperture_offset = ~off;
  endtask : acc
endmodule : atd_host_model
`default_nettype wire

// file: verif/test_aperture_tiled_region_detiler.sv
`timescale 1ns/10ps
`default_nettype none
module test_aperture_tiled_region_detiler;
  import atd_pkg::*;
  logic ref_clk, srst, reg_wr, reg_rd, reg_rvalid, req_valid, req_is_host, out_valid;
  logic req_private_gfx_space, req_explicit_tiled, req_explicit_walk_y, out_tiled;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [63:0]           reg_wdata, reg_rdata, d;
  logic [9:0]            req_explicit_pitch;
  logic [ADDR_W-1:0]     req_graphics_aperture_offset, req_explicit_base, out_addr;
  int                    err_total, compares, i, k, px, py, pe, lin, eb;
  logic [63:0]           shadow [$];
  atd_detiler atd_detiler_inst (.ref_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .req_valid, .req_is_host, .req_private_gfx_space,
    .req_graphics_aperture_offset, .req_explicit_tiled, .req_explicit_walk_y,
    .req_explicit_pitch, .req_explicit_base, .out_valid, .out_tiled, .out_addr);
  atd_host_model atd_host_model_inst (.ref_clk, .reg_rdata, .reg_rvalid, .out_valid,
    .out_tiled, .out_addr, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .req_valid,
    .req_is_host, .req_private_gfx_space, .req_graphics_aperture_offset,
    .req_explicit_tiled, .req_explicit_walk_y, .req_explicit_pitch, .req_explicit_base);
  initial
  begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic int tofs(int lin, int pt, bit wy);
    int tw, y, xin;
    tw = wy ? 128 : 512;
    xin = lin % tw;
    y = (lin / tw) / pt;
    if (wy)
      return pt * 4096 * (y / 32) + 4096 * ((lin / tw) % pt) + 512 * (xin / 16) + 16 * (y % 32) + xin % 16;
    return pt * 4096 * (y / 8) + 4096 * ((lin / tw) % pt) + 512 * (y % 8) + xin;
  endfunction : tofs
  task close_out;
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task chk(input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task rdc(input logic [23:0] a, input logic [63:0] exp);
    logic [63:0] r;
    bit ok;
    atd_host_model_inst.rd(a, r, ok);
    if (!ok)
    begin
      err_total++;
      close_out();
    end
    chk(r, exp);
  endtask : rdc
  task go(input bit h, p, et, ewy, input int ep, eb, off, ea, input bit et_exp);
    logic [31:0] a;
    logic        t, v;
    atd_host_model_inst.acc(h, p, et, ewy, ep[9:0], eb, off, a, t, v);
    chk(v, 1);
    chk(t, et_exp);
    chk(a, ea);
  endtask : go
  function automatic logic [63:0] desc(int first, int pf, bit wy, bit vld);
    return {20'(first + 15), 2'h0, 10'(pf), 20'(first), 10'h0, wy, vld};
  endfunction : desc
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    compares = 0;
    srst = 1;
    void'($urandom(32'h65c2f105));
    repeat (20) @(negedge ref_clk);
    srst = 0;
    for (i = 0; i < 16; i++) rdc(REGION_BASE + 8 * i, 64'h0);
    for (i = 0; i < 16; i++)
    begin
      d = {$urandom, $urandom};
      shadow.push_back(d);
      atd_host_model_inst.wr(REGION_BASE + 8 * i, d);
      rdc(REGION_BASE + 8 * i, shadow[i]);
    end
    atd_host_model_inst.wr(REGION_BASE + 4, 64'h0);
    rdc(REGION_BASE + 4, 64'h0);
    rdc(REGION_BASE, shadow[0]);
    rdc(24'h100080, 64'h0);
    for (i = 0; i < 16; i++) atd_host_model_inst.wr(REGION_BASE + 8 * i, 64'h0);
    // Disjoint regions, one of them never valid
    px = 1 + $urandom % 4;
    py = 1 + $urandom % 8;
    atd_host_model_inst.wr(REGION_BASE + 24, desc(16, 4 * px - 1, 0, 1));
    atd_host_model_inst.wr(REGION_BASE + 40, desc(64, py - 1, 1, 1));
    atd_host_model_inst.wr(REGION_BASE + 56, desc(128, 3, 0, 0));
    go(1, 0, 0, 0, 0, 0, 32'hffff, 32'hffff, 0);
    go(1, 0, 0, 0, 0, 0, 32'h20000, 32'h20000, 0);
    go(1, 0, 0, 0, 0, 0, 32'h1ffff, 32'h10000 + tofs(65535, px, 0), 1);
    for (k = 0; k < 24; k++)
    begin
      lin = (k == 0) ? 0 : $urandom % 65536;
      pe = 1 + $urandom % 8;
      eb = ($urandom % 256) << 12;
      go(1, 0, 0, 0, 0, 0, 32'h10000 + lin, 32'h10000 + tofs(lin, px, 0), 1);
      go(1, 0, 0, 0, 0, 0, 32'h40000 + lin, 32'h40000 + tofs(lin, py, 1), 1);
      go(1, 0, 0, 0, 0, 0, 32'h80000 + lin, 32'h80000 + lin, 0);
      go(1, 1, 0, 0, 0, 0, 32'h10000 + lin, 32'h10000 + lin, 0);
      go(0, 0, 0, 0, 0, 0, 32'h40000 + lin, 32'h40000 + lin, 0);
      go(0, 0, 1, k % 2, pe, eb, lin, eb + tofs(lin, pe, k % 2), 1);
      go(0, 0, 1, 0, 0, 0, lin, tofs(lin, 1, 0), 1);
    end
    // Widest pitch of each walk
    lin = $urandom % 65536;
    atd_host_model_inst.wr(REGION_BASE + 24, desc(16, 1023, 0, 1));
    atd_host_model_inst.wr(REGION_BASE + 40, desc(64, 1023, 1, 1));
    go(1, 0, 0, 0, 0, 0, 32'h10000 + lin, 32'h10000 + tofs(lin, 256, 0), 1);
    go(1, 0, 0, 0, 0, 0, 32'h40000 + lin, 32'h40000 + tofs(lin, 1024, 1), 1);
    atd_host_model_inst.wr(REGION_BASE + 24, desc(16, 4 * px - 1, 0, 0));
    go(1, 0, 0, 0, 0, 0, 32'h10040, 32'h10040, 0);
    close_out();
  end
endmodule : test_aperture_tiled_region_detiler
`default_nettype wire
